// file: core/sdc_pkg.sv
/*
  sdc_pkg: shared constants and types of the synthesizer divider configuration block.
  assumes: included first in compile order; no other package is needed.
*/
`default_nettype none

package sdc_pkg;

  // ----------------------------------------------------------------------------
  // configuration word
  // ----------------------------------------------------------------------------
  localparam int unsigned SDC_M_W    = 9;
  localparam int unsigned SDC_N_W    = 2;
  localparam int unsigned SDC_T_W    = 3;
  localparam int unsigned SDC_SR_W   = 14;
  localparam int unsigned SDC_REF_PRESCALE = 8;

  // serial word layout, first shifted bit ends up highest
  localparam int unsigned SDC_SR_T_LSB = 11;
  localparam int unsigned SDC_SR_N_LSB = 9;
  localparam int unsigned SDC_SR_M_LSB = 0;

  typedef struct packed {
    logic [SDC_T_W-1:0] t;
    logic [SDC_N_W-1:0] n;
    logic [SDC_M_W-1:0] m;
  } sdc_cfg_type;

  // pins float high, so a reset image matches an unloaded part
  localparam sdc_cfg_type SDC_CFG_RESET = '{t: 3'h0, n: 2'h3, m: 9'h1ff};
  localparam logic [SDC_SR_W-1:0] SDC_SR_RESET = 14'h0000;
  // idle pull levels of {oe, xtal, ext ref, ref select, p load, s clock, s data, s load, m, n}
  localparam logic [SDC_M_W+SDC_N_W+7:0] SDC_PIN_IDLE = 19'h4c7ff;

  // ----------------------------------------------------------------------------
  // output divider codes and test selections
  // ----------------------------------------------------------------------------
  localparam logic [SDC_M_W-1:0] SDC_NMOD_1 = 9'h001;
  localparam logic [SDC_M_W-1:0] SDC_NMOD_2 = 9'h002;
  localparam logic [SDC_M_W-1:0] SDC_NMOD_4 = 9'h004;
  localparam logic [SDC_M_W-1:0] SDC_NMOD_8 = 9'h008;
  localparam logic [SDC_M_W-1:0] SDC_TEST_QUARTER = 9'h004;

  typedef enum logic [SDC_T_W-1:0] {
    SDC_T_SHIFT_OUT = 3'h0,
    SDC_T_HIGH      = 3'h1,
    SDC_T_REF       = 3'h2,
    SDC_T_MCOUNT    = 3'h3,
    SDC_T_SYNTH     = 3'h4,
    SDC_T_LOW       = 3'h5,
    SDC_T_BYPASS    = 3'h6,
    SDC_T_SYNTH_DIV4 = 3'h7
  } sdc_test_type;

  // ----------------------------------------------------------------------------
  // reference period measurement
  // ----------------------------------------------------------------------------
  localparam int unsigned SDC_PER_W = 18;
  localparam logic [2:0]  SDC_REF_LAST = 3'h7;

  // ----------------------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------------------
  localparam int unsigned SDC_ADDR_W = 4;
  localparam int unsigned SDC_DATA_W = 32;
  localparam logic [SDC_ADDR_W-1:0] SDC_OFS_CTRL   = 4'h0;
  localparam logic [SDC_ADDR_W-1:0] SDC_OFS_CONFIG = 4'h4;
  localparam logic [SDC_ADDR_W-1:0] SDC_OFS_STATUS = 4'h8;
  localparam logic SDC_CTRL_RESET = 1'b1;

endpackage : sdc_pkg

`default_nettype wire

// file: core/sdc_div.sv
/*
  sdc_div: tick-driven divider; toggles its level after a programmable count of ticks.
  assumes: ticks are single-cycle pulses on i_clk; modulus 0 acts as 1.
*/
`default_nettype none

module sdc_div
  import sdc_pkg::*;
(
  // clock and control
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_ce,
  // tick stream and modulus
  input  wire logic               i_tick,
  input  wire logic [SDC_M_W-1:0] i_modulus,
  // divided output
  output logic                    o_level,
  output logic                    o_toggle
);

  logic [SDC_M_W-1:0] count;
  logic [SDC_M_W-1:0] next_count;
  logic               wrap;

  assign next_count = count + 9'h001;
  assign wrap       = (next_count >= i_modulus);
  assign o_toggle   = i_ce && i_tick && wrap;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count   <= 9'h000;
      o_level <= 1'b0;
    end else if (i_ce && i_tick) begin
      if (wrap) begin
        count   <= 9'h000;
        o_level <= !o_level;
      end else begin
        count <= next_count;
      end
    end
  end

endmodule : sdc_div

`default_nettype wire

// file: core/sdc_top.sv
/*
  sdc_top: configuration and divider logic of a crystal referenced clock synthesizer.
  assumes: all configuration pins and the reference come from outside the clock domain;
  the reference runs far below i_clk/2 and the loop frequency stays below i_clk.
*/
// The address-and-strobe port and the register offsets were left to the implementer.
`default_nettype none

module sdc_top
  import sdc_pkg::*;
(
  // clock, reset, enable
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_ce,
  // reference sources
  input  wire logic                  i_xtal_ref,
  input  wire logic                  i_external_reference_in,
  input  wire logic                  i_ref_sel,
  // parallel configuration
  input  wire logic                  i_p_load,
  input  wire logic [SDC_M_W-1:0]    i_m_pins,
  input  wire logic [SDC_N_W-1:0]    i_n_pins,
  // serial configuration
  input  wire logic                  i_s_clock,
  input  wire logic                  i_s_data,
  input  wire logic                  i_s_load,
  // output enable pin
  input  wire logic                  i_oe,
  // register port
  input  wire logic [SDC_ADDR_W-1:0] i_addr,
  input  wire logic [SDC_DATA_W-1:0] i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic      [SDC_DATA_W-1:0] o_rdata,
  // synthesizer outputs
  output logic                       o_synth_output,
  output logic                       o_test
);

  // ----------------------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------------------
  logic [1:0] rst_pipe;
  logic       rst_n;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  localparam int unsigned PIN_W = 8 + SDC_M_W + SDC_N_W;
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic             xtal_s, ext_s, sel_s, pl_s, sclk_s, sdat_s, sl_s, oe_s;
  logic [SDC_M_W-1:0] m_s;
  logic [SDC_N_W-1:0] n_s;

  // first stage feeds only the second; reset to pull levels so release shows no false load
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= SDC_PIN_IDLE;
      pin_sync <= SDC_PIN_IDLE;
    end else if (i_ce) begin
      pin_meta <= {i_oe, i_xtal_ref, i_external_reference_in, i_ref_sel, i_p_load, i_s_clock,
                   i_s_data, i_s_load, i_m_pins, i_n_pins};
      pin_sync <= pin_meta;
    end
  end
  assign {oe_s, xtal_s, ext_s, sel_s, pl_s, sclk_s, sdat_s, sl_s, m_s, n_s} = pin_sync;

  // ----------------------------------------------------------------------------
  // serial shift register
  // ----------------------------------------------------------------------------
  logic                sclk_d;
  logic                sclk_rise;
  logic [SDC_SR_W-1:0] shift;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d <= 1'b0;
    end else if (i_ce) begin
      sclk_d <= sclk_s;
    end
  end
  assign sclk_rise = sclk_s && !sclk_d;
  // msb of each field enters first
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift <= SDC_SR_RESET;
    end else if (i_ce && sclk_rise) begin
      shift <= {shift[SDC_SR_W-2:0], sdat_s};
    end
  end

  // ----------------------------------------------------------------------------
  // configuration latches
  // ----------------------------------------------------------------------------
  sdc_cfg_type cfg;
  sdc_cfg_type shift_cfg;
  assign shift_cfg = '{t: shift[SDC_SR_T_LSB +: SDC_T_W],
                       n: shift[SDC_SR_N_LSB +: SDC_N_W],
                       m: shift[SDC_SR_M_LSB +: SDC_M_W]};

  // transparent while parallel load low; the last value stays at the rise
  // pins map straight to loop and output divider fields
  // serial path only when parallel load is high
  // test bits cleared under parallel load
  // serial path transparent while its load is high
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= SDC_CFG_RESET;
    end else if (i_ce) begin
      if (!pl_s) begin
        cfg <= '{t: 3'h0, n: n_s, m: m_s};
      end else if (sl_s) begin
        cfg <= shift_cfg;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // reference selection and period measurement
  // ----------------------------------------------------------------------------
  logic                 ref_lvl;
  logic                 ref_d;
  logic [2:0]           ref_cnt;
  logic [SDC_PER_W-1:0] per_cnt;
  logic [SDC_PER_W-1:0] per8;

  assign ref_lvl = sel_s ? xtal_s : ext_s;
  // counts clock cycles across eight reference periods, the prescaled reference
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_d   <= 1'b0;
      ref_cnt <= 3'h0;
      per_cnt <= '0;
      per8    <= '0;
    end else if (i_ce) begin
      ref_d   <= ref_lvl;
      per_cnt <= per_cnt + 18'h00001;
      if (ref_lvl && !ref_d) begin
        ref_cnt <= ref_cnt + 3'h1;
        if (ref_cnt == SDC_REF_LAST) begin
          per8    <= per_cnt;
          per_cnt <= '0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // loop model: vco half-period ticks at 2*M*fref/8
  // ----------------------------------------------------------------------------
  logic [SDC_PER_W-1:0] acc;
  logic [SDC_PER_W-1:0] acc_sum;
  logic [SDC_PER_W-1:0] acc_diff;
  logic                 vco_tick;
  assign acc_sum  = acc + {{(SDC_PER_W-SDC_M_W-1){1'b0}}, cfg.m, 1'b0};
  assign acc_diff = acc_sum - per8;
  assign vco_tick = (per8 != '0) && (acc_sum >= per8);

  // the rate scales with M over the prescaled reference period
  // a new M only changes the rate; the phase runs on, no restart
  // limitation: the vco saturates at one tick a cycle when 2M exceeds the period
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= '0;
    end else if (i_ce) begin
      if (!vco_tick) begin
        acc <= acc_sum;
      end else if (acc_diff >= per8) begin
        acc <= '0;
      end else begin
        acc <= acc_diff;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // dividers
  // ----------------------------------------------------------------------------
  logic               bypass;
  logic               div_tick;
  logic [SDC_M_W-1:0] n_mod;
  logic               n_level;
  logic               n_toggle;
  logic               m_level;
  logic               q_level;
  // serial clock replaces the vco in bypass
  assign bypass   = (cfg.t == SDC_T_BYPASS);
  assign div_tick = bypass ? sclk_rise : vco_tick;

  always_comb begin
    case (cfg.n)
      2'h0:    n_mod = SDC_NMOD_1;
      2'h1:    n_mod = SDC_NMOD_4;
      2'h2:    n_mod = SDC_NMOD_2;
      2'h3:    n_mod = SDC_NMOD_8;
      default: n_mod = SDC_NMOD_1;
    endcase
  end

  sdc_div u_ndiv (
    .i_clk     (i_clk),
    .i_rst_n   (rst_n),
    .i_ce      (i_ce),
    .i_tick    (div_tick),
    .i_modulus (n_mod),
    .o_level   (n_level),
    .o_toggle  (n_toggle)
  );

  sdc_div u_mdiv (
    .i_clk     (i_clk),
    .i_rst_n   (rst_n),
    .i_ce      (i_ce),
    .i_tick    (div_tick),
    .i_modulus (cfg.m),
    .o_level   (m_level),
    .o_toggle  ()
  );

  sdc_div u_qdiv (
    .i_clk     (i_clk),
    .i_rst_n   (rst_n),
    .i_ce      (i_ce),
    .i_tick    (n_toggle),
    .i_modulus (SDC_TEST_QUARTER),
    .o_level   (q_level),
    .o_toggle  ()
  );

  // ----------------------------------------------------------------------------
  // synchronous enable and outputs
  // ----------------------------------------------------------------------------
  logic sw_enable;
  logic oe_eff;
  // enable moves only while the divided clock is low
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_eff <= 1'b0;
    end else if (i_ce && !n_level) begin
      oe_eff <= oe_s && sw_enable;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_synth_output <= 1'b0;
    end else if (i_ce) begin
      o_synth_output <= n_level && oe_eff;
    end
  end

  // test pin source from serial test bits
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_test <= 1'b0;
    end else if (i_ce) begin
      case (sdc_test_type'(cfg.t))
        SDC_T_SHIFT_OUT:  o_test <= shift[SDC_SR_W-1];
        SDC_T_HIGH:       o_test <= 1'b1;
        SDC_T_REF:        o_test <= ref_lvl;
        SDC_T_MCOUNT:     o_test <= m_level;
        SDC_T_SYNTH:      o_test <= n_level;
        SDC_T_LOW:        o_test <= 1'b0;
        SDC_T_BYPASS:     o_test <= m_level;
        SDC_T_SYNTH_DIV4: o_test <= q_level;
        default:          o_test <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_enable <= SDC_CTRL_RESET;
    end else if (i_ce && i_wr && (i_addr == SDC_OFS_CTRL)) begin
      sw_enable <= i_wdata[0];
    end
  end

  // read data stands for one cycle only, zero otherwise and for unmapped offsets
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= '0;
    end else if (i_ce) begin
      o_rdata <= '0;
      if (i_rd) begin
        case (i_addr)
          SDC_OFS_CTRL:   o_rdata <= {31'h0, sw_enable};
          SDC_OFS_CONFIG: o_rdata <= {18'h0, cfg};
          SDC_OFS_STATUS: o_rdata <= {28'h0, pl_s, sel_s, oe_eff, bypass};
          default:        o_rdata <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n || !i_ce);

  sequence s_serial_open;
    pl_s && sl_s;
  endsequence

  sequence s_serial_close;
    s_serial_open ##1 (pl_s && !sl_s);
  endsequence

  chk_serial_follow: assert property (s_serial_open |=> cfg == $past(shift_cfg))
    else $error("serial latch did not follow shift register");
  chk_serial_hold: assert property (s_serial_close |=> $stable(cfg))
    else $error("serial latch changed after load fell");
  chk_shift_in: assert property (sclk_rise |=> shift == {$past(shift[SDC_SR_W-2:0]), $past(sdat_s)})
    else $error("serial bit not shifted in");
  chk_parallel_follow: assert property (!pl_s |=> cfg.m == $past(m_s) && cfg.n == $past(n_s))
    else $error("parallel latch not transparent");
  chk_test_cleared: assert property (!pl_s |=> cfg.t == 3'h0)
    else $error("test bits not cleared under parallel load");
  chk_serial_blocked: assert property ((pl_s && !sl_s) ##1 (pl_s && !sl_s) |-> $stable(cfg))
    else $error("configuration moved without a load");
  chk_nmod_four: assert property (cfg.n == 2'h1 |-> n_mod == SDC_NMOD_4)
    else $error("code 01 not divide by four");
  chk_enable_low: assert property ($changed(oe_eff) |-> !$past(n_level))
    else $error("enable changed while output high");
  chk_no_runt: assert property ($rose(o_synth_output) |=> o_synth_output || $past(n_toggle, 2))
    else $error("output pulse cut short");
  chk_bypass_test: assert property (bypass ##1 bypass |-> o_test == $past(m_level))
    else $error("bypass test pin not loop counter");
  chk_ref_select: assert property (sel_s |-> ref_lvl == xtal_s)
    else $error("crystal not selected");

endmodule : sdc_top

`default_nettype wire

// file: bench/sdc_board_model.sv
/*
  sdc_board_model: board controller that drives the parallel and serial configuration pins.
  assumes: shares i_clk with the block; the bench calls its tasks; idle load and serial pins sit at pull levels.
*/
`default_nettype none

module sdc_board_model
  import sdc_pkg::*;
(
  // clock
  input  wire logic               i_clk,
  // configuration pins
  output var  logic               o_p_load,
  output var  logic [SDC_M_W-1:0] o_m_pins,
  output var  logic [SDC_N_W-1:0] o_n_pins,
  output var  logic               o_s_clock,
  output var  logic               o_s_data,
  output var  logic               o_s_load
);
  timeunit 1ns;
  timeprecision 100ps;

  // pull-ups on parallel pins, pull-downs on serial pins
  initial begin
    o_p_load  = 1'b1;
    o_m_pins  = 9'h1ff;
    o_n_pins  = 2'h3;
    o_s_clock = 1'b0;
    o_s_data  = 1'b0;
    o_s_load  = 1'b0;
  end

  task automatic set_pins(input logic [SDC_M_W-1:0] m, input logic [SDC_N_W-1:0] n);
    @(posedge i_clk);
    o_m_pins <= m;
    o_n_pins <= n;
    repeat (8) @(posedge i_clk);
  endtask : set_pins

  // callers keep m in range and pick n by band
  task automatic par_load(input logic [SDC_M_W-1:0] m, input logic [SDC_N_W-1:0] n, input logic rise);
    @(posedge i_clk);
    o_p_load <= 1'b0;
    o_m_pins <= m;
    o_n_pins <= n;
    repeat (8) @(posedge i_clk);
    o_p_load <= rise;
    repeat (8) @(posedge i_clk);
  endtask : par_load

  // slow enough that the block sees each level for several cycles
  task automatic sclk_pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge i_clk);
      o_s_clock <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_s_clock <= 1'b0;
      repeat (4) @(posedge i_clk);
    end
  endtask : sclk_pulses

  task automatic load_pulse();
    @(posedge i_clk);
    o_s_load <= 1'b1;
    repeat (6) @(posedge i_clk);
    o_s_load <= 1'b0;
    repeat (6) @(posedge i_clk);
  endtask : load_pulse

  // msb first, data released to pull level between bits
  task automatic ser_word(input logic [SDC_SR_W-1:0] w, input logic load);
    for (int i = SDC_SR_W - 1; i >= 0; i--) begin
      @(posedge i_clk);
      o_s_data <= w[i];
      sclk_pulses(1);
      o_s_data <= 1'b0;
    end
    if (load) begin
      load_pulse();
    end
  endtask : ser_word

endmodule : sdc_board_model

`default_nettype wire

// file: bench/sdc_top_bench.sv
/*
  sdc_top_bench: self-checking bench for sdc_top with a board controller model.
  assumes: 200 MHz i_clk, references slow enough that the loop never saturates.
*/
`default_nettype none

module sdc_top_bench
  import sdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic                  i_clk, i_rst_n, i_ce, i_xtal_ref, i_external_reference_in, i_ref_sel;
  logic                  i_p_load, i_s_clock, i_s_data, i_s_load, i_oe, i_wr, i_rd;
  logic [SDC_M_W-1:0]    i_m_pins;
  logic [SDC_N_W-1:0]    i_n_pins;
  logic [SDC_ADDR_W-1:0] i_addr;
  logic [SDC_DATA_W-1:0] i_wdata, o_rdata;
  logic                  o_synth_output, o_test;
  int                    err_total = 0;
  int                    n_checks  = 0;

  sdc_top sdc_top_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_xtal_ref(i_xtal_ref),
    .i_external_reference_in(i_external_reference_in), .i_ref_sel(i_ref_sel), .i_p_load(i_p_load),
    .i_m_pins(i_m_pins), .i_n_pins(i_n_pins), .i_s_clock(i_s_clock), .i_s_data(i_s_data),
    .i_s_load(i_s_load), .i_oe(i_oe), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_synth_output(o_synth_output), .o_test(o_test));

  sdc_board_model sdc_board_model_i (.i_clk(i_clk), .o_p_load(i_p_load), .o_m_pins(i_m_pins),
    .o_n_pins(i_n_pins), .o_s_clock(i_s_clock), .o_s_data(i_s_data), .o_s_load(i_s_load));

  // ----------------------------------------------------------------------------
  // clocks and references
  // ----------------------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // crystal 1 MHz, external 2 MHz, phases unrelated to i_clk
  initial begin
    i_xtal_ref = 1'b0;
    #3.1;
    forever #500 i_xtal_ref = ~i_xtal_ref;
  end
  initial begin
    i_external_reference_in = 1'b0;
    #7.3;
    forever #250 i_external_reference_in = ~i_external_reference_in;
  end

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [SDC_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [SDC_ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1;
    d = o_rdata;
  endtask : rd_reg

  // rises and shortest complete high run; optionally toggles the enable pin
  task automatic watch(input int cycles, input int tog, output int rises, output int min_hi);
    logic prev;
    int   run;
    prev   = o_synth_output;
    run    = prev ? -1 : 0;
    rises  = 0;
    min_hi = 1 << 20;
    for (int k = 1; k <= cycles; k++) begin
      @(posedge i_clk);
      if (tog > 0 && k % tog == 0) i_oe <= ~i_oe;
      #1;
      if (o_synth_output && !prev) rises++;
      if (o_synth_output && run >= 0) run++;
      if (!o_synth_output && prev && run > 0 && run < min_hi) min_hi = run;
      if (!o_synth_output) run = 0;
      prev = o_synth_output;
    end
  endtask : watch

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    rd_reg(SDC_OFS_CONFIG, d);
    check("config reset", d, {18'h0, SDC_CFG_RESET});
    rd_reg(SDC_OFS_CTRL, d);
    check("ctrl reset", d, 32'h00000001);
    wr_reg(4'hc, 32'hffffffff);
    rd_reg(4'hc, d);
    check("unmapped", d, 32'h00000000);
  endtask : t_regs

  task automatic t_parallel();
    logic [31:0] d;
    sdc_board_model_i.par_load(9'h106, 2'h1, 1'b0);
    rd_reg(SDC_OFS_CONFIG, d);
    check("parallel open", d, {18'h0, 3'h0, 2'h1, 9'h106});
    sdc_board_model_i.par_load(9'h155, 2'h2, 1'b1);
    sdc_board_model_i.set_pins(9'h0f0, 2'h0);
    rd_reg(SDC_OFS_CONFIG, d);
    check("parallel held", d, {18'h0, 3'h0, 2'h2, 9'h155});
  endtask : t_parallel

  task automatic t_serial();
    logic [31:0] d;
    sdc_board_model_i.ser_word({3'h5, 2'h2, 9'h123}, 1'b1);
    rd_reg(SDC_OFS_CONFIG, d);
    check("serial word", d, {18'h0, 3'h5, 2'h2, 9'h123});
    check("test low", {31'h0, o_test}, 32'h0);
    sdc_board_model_i.ser_word({3'h1, 2'h0, 9'h0c8}, 1'b0);
    rd_reg(SDC_OFS_CONFIG, d);
    check("serial held", d, {18'h0, 3'h5, 2'h2, 9'h123});
    sdc_board_model_i.load_pulse();
    rd_reg(SDC_OFS_CONFIG, d);
    check("serial loaded", d, {18'h0, 3'h1, 2'h0, 9'h0c8});
    check("test high", {31'h0, o_test}, 32'h1);
    sdc_board_model_i.par_load(9'h120, 2'h1, 1'b0);
    sdc_board_model_i.load_pulse();
    rd_reg(SDC_OFS_CONFIG, d);
    check("parallel wins", d, {18'h0, 3'h0, 2'h1, 9'h120});
    sdc_board_model_i.par_load(9'h120, 2'h1, 1'b1);
  endtask : t_serial

  task automatic t_freq();
    int div[4]  = '{1, 4, 2, 8};
    int mv[5]   = '{256, 256, 256, 256, 264};
    int code[5] = '{0, 1, 2, 3, 3};
    int r, mh, e;
    for (int i = 0; i < 5; i++) begin
      sdc_board_model_i.par_load(mv[i][8:0], code[i][1:0], 1'b1);
      repeat (3200) @(posedge i_clk);
      watch(3200, 0, r, mh);
      e = 2 * mv[i] / div[code[i]];
      check("rise count", {31'h0, (r >= e - 1 && r <= e + 1)}, 32'h1);
    end
  endtask : t_freq

  task automatic t_refsel();
    int r, mh;
    i_ref_sel <= 1'b0;
    sdc_board_model_i.par_load(9'h100, 2'h1, 1'b1);
    repeat (3200) @(posedge i_clk);
    watch(3200, 0, r, mh);
    check("external ref", {31'h0, (r >= 255 && r <= 257)}, 32'h1);
    @(posedge i_clk);
    i_ref_sel <= 1'b1;
  endtask : t_refsel

  task automatic t_enable();
    logic [31:0] d;
    int r, mh;
    sdc_board_model_i.par_load(9'h100, 2'h3, 1'b1);
    repeat (3200) @(posedge i_clk);
    i_oe <= 1'b0;
    repeat (200) @(posedge i_clk);
    watch(1000, 0, r, mh);
    check("pin disable", r, 0);
    @(posedge i_clk);
    i_oe <= 1'b1;
    watch(2000, 37, r, mh);
    check("some pulses", {31'h0, r > 0}, 32'h1);
    check("no runt", {31'h0, mh >= 24}, 32'h1);
    @(posedge i_clk);
    i_oe <= 1'b1;
    wr_reg(SDC_OFS_CTRL, 32'h0);
    rd_reg(SDC_OFS_CTRL, d);
    check("ctrl write", d, 32'h0);
    repeat (200) @(posedge i_clk);
    watch(1000, 0, r, mh);
    check("sw disable", r, 0);
    wr_reg(SDC_OFS_CTRL, 32'h1);
    // a frozen block must not move its output although the loop was running
    repeat (100) @(posedge i_clk);
    i_ce <= 1'b0;
    watch(200, 0, r, mh);
    check("frozen", r, 0);
    @(posedge i_clk);
    i_ce <= 1'b1;
  endtask : t_enable

  task automatic t_bypass();
    logic [31:0] d;
    int r, mh;
    sdc_board_model_i.ser_word({3'h6, 2'h0, 9'h004}, 1'b1);
    rd_reg(SDC_OFS_STATUS, d);
    check("bypass flag", {31'h0, d[0]}, 32'h1);
    fork
      sdc_board_model_i.sclk_pulses(8);
      watch(120, 0, r, mh);
    join
    check("bypass rises", r, 4);
  endtask : t_bypass

  // ----------------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------------
  initial begin
    i_rst_n   = 1'b0;
    i_ce      = 1'b1;
    i_ref_sel = 1'b1;
    i_oe      = 1'b1;
    i_addr    = 4'h0;
    i_wdata   = 32'h0;
    i_wr      = 1'b0;
    i_rd      = 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (8) @(posedge i_clk);
    t_regs();
    t_parallel();
    t_serial();
    t_freq();
    t_refsel();
    t_enable();
    t_bypass();
    report_and_stop();
  end

  initial begin
    #450000;
    err_total++;
    report_and_stop();
  end

endmodule : sdc_top_bench

`default_nettype wire
